/* hdl/tcm_defines.svh */
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH
// Operation
// - both open: cutoff, stop, code 40
// - both closed: no cutoff, running allowed
// - one open: code 41 or 42
// - both channels abnormal: code 43
// - output off within 10 ms
// - exception indication within 280 ms
// - cutoff indication within 100 ms
// - cutoff forces all gate drives inactive
// - start ignored while cutoff active
// - no braking; output removed, motor coasts
// - resume only after new start command

`define TCM_CLK_MHZ 100
`define TCM_TRIG_MS 10
`define TCM_IND_EXC_MS 280
`define TCM_IND_CUT_MS 100
// longest times as whole cycles, less one cycle
`define TCM_TRIG_CYC (`TCM_TRIG_MS * 1000 * `TCM_CLK_MHZ - 1)
`define TCM_IND_EXC_CYC (`TCM_IND_EXC_MS * 1000 * `TCM_CLK_MHZ - 1)
`define TCM_IND_CUT_CYC (`TCM_IND_CUT_MS * 1000 * `TCM_CLK_MHZ - 1)
// default disagreement tolerance: 5 ms, inside the trigger budget
`define TCM_TOL_CYC (5 * 1000 * `TCM_CLK_MHZ)
`define TCM_IND_DLY_CYC 2

`define TCM_CODE_NONE 8'h00
`define TCM_CODE_CUTOFF 8'h28
`define TCM_CODE_EXC_A 8'h29
`define TCM_CODE_EXC_B 8'h2a
`define TCM_CODE_EXC_AB 8'h2b
`endif

/* hdl/tcm_pkg.sv */
package tcm_pkg;
  typedef enum logic [2:0] {
    TCM_IDLE,
    TCM_RUN,
    TCM_CUTOFF,
    TCM_EXCEPTION
  } tcm_state_t;

  typedef enum logic [1:0] {
    TCM_CH_CLOSED,
    TCM_CH_OPEN,
    TCM_CH_SPLIT_A,
    TCM_CH_SPLIT_B
  } tcm_chan_t;
endpackage

/* hdl/tcm_chan_judge.sv */
`include "tcm_defines.svh"
module tcm_chan_judge
  import tcm_pkg::*;
#(
  parameter int TOL_CYC = `TCM_TOL_CYC
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clk_en, // freezes state while low
  input wire logic safety_input_a, // channel a, high = closed
  input wire logic safety_input_b, // channel b, high = closed
  output tcm_chan_t chan_state, // judged channel state
  output logic split_timeout // disagreement held beyond window
);
  localparam int CW = $clog2(TOL_CYC + 2);
  logic [CW-1:0] cnt_reg, cnt_next;
  logic to_reg, to_next;

  always_comb begin
    cnt_next = cnt_reg;
    to_next = to_reg;
    if (safety_input_a != safety_input_b) begin
      if (cnt_reg >= CW'(TOL_CYC)) begin
        to_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end else begin
      cnt_next = '0;
      to_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      to_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      to_reg <= to_next;
    end
  end

  always_comb begin
    case ({safety_input_a, safety_input_b})
      2'b11: chan_state = TCM_CH_CLOSED;
      2'b00: chan_state = TCM_CH_OPEN;
      2'b01: chan_state = TCM_CH_SPLIT_A;
      default: chan_state = TCM_CH_SPLIT_B;
    endcase
  end

  assign split_timeout = to_reg;
endmodule

/* hdl/tcm_ind_delay.sv */
`include "tcm_defines.svh"
module tcm_ind_delay #(
  parameter int DLY = `TCM_IND_DLY_CYC
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clk_en, // freezes state while low
  input wire logic [7:0] code_in, // latched fault code
  output logic [7:0] code_out // code shown after fixed delay
);
  logic [7:0] pipe_reg [DLY];
  logic [7:0] pipe_next [DLY];

  always_comb begin
    pipe_next[0] = code_in;
    for (int i = 1; i < DLY; i++) begin
      pipe_next[i] = pipe_reg[i-1];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < DLY; i++) begin
      if (!rst_n) begin
        pipe_reg[i] <= `TCM_CODE_NONE;
      end else if (clk_en) begin
        pipe_reg[i] <= pipe_next[i];
      end
    end
  end

  assign code_out = pipe_reg[DLY-1];
endmodule

/* hdl/torque_cutoff_monitor.sv */
`include "tcm_defines.svh"
module torque_cutoff_monitor
  import tcm_pkg::*;
#(
  parameter int TOL_CYC = `TCM_TOL_CYC,
  parameter int GATES = 6,
  parameter int IND_DLY = `TCM_IND_DLY_CYC
) (
  input wire logic ref_clk, // system clock, 100 mhz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic safety_input_a, // channel a contact, high = closed
  input wire logic safety_input_b, // channel b contact, high = closed
  input wire logic start_cmd, // start request, one-cycle pulse
  input wire logic stop_cmd, // normal stop request, one-cycle pulse
  input wire logic fault_reset, // fault reset request, one-cycle pulse
  input wire logic [GATES-1:0] gate_drive_in, // modulator gate commands
  output logic [GATES-1:0] gate_drive_out, // gated power-stage drives
  output logic running, // drive is running
  output logic safe_torque_cutoff, // cutoff active, level
  output logic channel_a_exception, // channel a fault latched
  output logic channel_b_exception, // channel b fault latched
  output logic dual_channel_exception, // both channels fault latched
  output logic [7:0] fault_code // indicated fault code
);
  tcm_chan_t chan_state;
  logic split_timeout;
  tcm_state_t state_reg, state_next;
  logic [7:0] code_reg, code_next;
  logic run_reg, run_next;
  logic [GATES-1:0] gate_reg, gate_next;
  logic exc_a_reg, exc_a_next;
  logic exc_b_reg, exc_b_next;
  logic exc_ab_reg, exc_ab_next;
  logic seen_a_reg, seen_a_next;
  logic seen_b_reg, seen_b_next;
  logic cut_reg, cut_next;
  logic split_hit;

  tcm_chan_judge #(.TOL_CYC(TOL_CYC)) u_judge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .safety_input_a(safety_input_a),
    .safety_input_b(safety_input_b),
    .chan_state(chan_state),
    .split_timeout(split_timeout)
  );

  tcm_ind_delay #(.DLY(IND_DLY)) u_ind (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .code_in(code_reg),
    .code_out(fault_code)
  );

  // the timeout flag is registered, so in the cycle the channels meet again it
  // is stale; acting on it then would blame a channel that is no longer open
  assign split_hit = split_timeout
    && (chan_state == TCM_CH_SPLIT_A || chan_state == TCM_CH_SPLIT_B);

  // a fault channel seen earlier is remembered so a later swap of the open
  // channel counts as both channels abnormal
  always_comb begin
    state_next = state_reg;
    code_next = code_reg;
    run_next = run_reg;
    exc_a_next = exc_a_reg;
    exc_b_next = exc_b_reg;
    exc_ab_next = exc_ab_reg;
    seen_a_next = seen_a_reg;
    seen_b_next = seen_b_reg;
    cut_next = cut_reg;
    case (state_reg)
      TCM_IDLE: begin
        run_next = 1'b0;
        if (chan_state == TCM_CH_OPEN) begin
          state_next = TCM_CUTOFF;
          code_next = `TCM_CODE_CUTOFF;
          cut_next = 1'b1;
        end else if (chan_state == TCM_CH_CLOSED && start_cmd) begin
          state_next = TCM_RUN;
          run_next = 1'b1;
        end
      end
      TCM_RUN: begin
        if (chan_state == TCM_CH_OPEN) begin
          state_next = TCM_CUTOFF;
          code_next = `TCM_CODE_CUTOFF;
          cut_next = 1'b1;
          run_next = 1'b0;
        end else if (stop_cmd) begin
          state_next = TCM_IDLE;
          run_next = 1'b0;
        end
      end
      TCM_CUTOFF: begin
        run_next = 1'b0;
        if (chan_state == TCM_CH_CLOSED && fault_reset) begin
          state_next = TCM_IDLE;
          code_next = `TCM_CODE_NONE;
          cut_next = 1'b0;
        end
      end
      TCM_EXCEPTION: begin
        run_next = 1'b0;
        if (chan_state == TCM_CH_CLOSED && fault_reset) begin
          state_next = TCM_IDLE;
          code_next = `TCM_CODE_NONE;
          exc_a_next = 1'b0;
          exc_b_next = 1'b0;
          exc_ab_next = 1'b0;
          seen_a_next = 1'b0;
          seen_b_next = 1'b0;
        end
      end
      default: begin
        state_next = TCM_IDLE;
        run_next = 1'b0;
      end
    endcase
    // an exception outranks a plain cutoff and may be raised from any state
    if (split_hit && state_reg != TCM_EXCEPTION) begin
      state_next = TCM_EXCEPTION;
      run_next = 1'b0;
      cut_next = 1'b0;
      if (chan_state == TCM_CH_SPLIT_A) begin
        seen_a_next = 1'b1;
        exc_a_next = 1'b1;
        code_next = `TCM_CODE_EXC_A;
      end else begin
        seen_b_next = 1'b1;
        exc_b_next = 1'b1;
        code_next = `TCM_CODE_EXC_B;
      end
    end else if (split_hit && state_reg == TCM_EXCEPTION) begin
      if (chan_state == TCM_CH_SPLIT_A && seen_b_reg && !exc_ab_reg) begin
        exc_ab_next = 1'b1;
        seen_a_next = 1'b1;
        code_next = `TCM_CODE_EXC_AB;
      end else if (chan_state == TCM_CH_SPLIT_B && seen_a_reg && !exc_ab_reg) begin
        exc_ab_next = 1'b1;
        seen_b_next = 1'b1;
        code_next = `TCM_CODE_EXC_AB;
      end
    end
  end

  // gates are cleared one cycle after the inputs open, far inside 10 ms;
  // no brake pattern is ever substituted, the stage simply goes dark
  always_comb begin
    if (run_next && chan_state == TCM_CH_CLOSED) begin
      gate_next = gate_drive_in;
    end else begin
      gate_next = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= TCM_IDLE;
      code_reg <= `TCM_CODE_NONE;
      run_reg <= 1'b0;
      gate_reg <= '0;
      exc_a_reg <= 1'b0;
      exc_b_reg <= 1'b0;
      exc_ab_reg <= 1'b0;
      seen_a_reg <= 1'b0;
      seen_b_reg <= 1'b0;
      cut_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      code_reg <= code_next;
      run_reg <= run_next;
      gate_reg <= gate_next;
      exc_a_reg <= exc_a_next;
      exc_b_reg <= exc_b_next;
      exc_ab_reg <= exc_ab_next;
      seen_a_reg <= seen_a_next;
      seen_b_reg <= seen_b_next;
      cut_reg <= cut_next;
    end
  end

  assign gate_drive_out = gate_reg;
  assign running = run_reg;
  assign safe_torque_cutoff = cut_reg;
  assign channel_a_exception = exc_a_reg;
  assign channel_b_exception = exc_b_reg;
  assign dual_channel_exception = exc_ab_reg;
endmodule

/* test/tcm_chk.sv */
module tcm_chk #(
  parameter int TOL_CYC = 8,
  parameter int GATES = 6,
  parameter int IND_DLY = 2
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic clk_en, // state enable
  input wire logic safety_input_a, // contact a
  input wire logic safety_input_b, // contact b
  input wire logic start_cmd, // start pulse
  input wire logic stop_cmd, // stop pulse
  input wire logic fault_reset, // fault reset pulse
  input wire logic [GATES-1:0] gate_drive_in, // modulator gates
  input wire logic [GATES-1:0] gate_drive_out, // power-stage gates
  input wire logic running, // running level
  input wire logic safe_torque_cutoff, // cutoff flag
  input wire logic channel_a_exception, // a flag
  input wire logic channel_b_exception, // b flag
  input wire logic dual_channel_exception, // dual flag
  input wire logic [7:0] fault_code // shown code
);
  timeunit 1ns;
  timeprecision 1ps;
  // two register stages plus one cycle of slack over the judge's own count
  localparam int EXC_LIM = TOL_CYC + 3;
  logic [31:0] split_cnt_reg;
  logic [31:0] split_cnt_next;
  logic any_flt;
  assign any_flt = safe_torque_cutoff | channel_a_exception | channel_b_exception
    | dual_channel_exception;
  always_comb begin
    split_cnt_next = (safety_input_a != safety_input_b) ? split_cnt_reg + 1 : 32'h0;
  end
  always_ff @(posedge ref_clk) begin
    split_cnt_reg <= rst_n ? split_cnt_next : 32'h0;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_CUT_TRIG: assert property (running && !safety_input_a && !safety_input_b
    |=> !running && safe_torque_cutoff && gate_drive_out == '0) else $error("cutoff late");
  AST_GATES_OFF: assert property (any_flt |-> gate_drive_out == '0)
    else $error("gates on in fault");
  AST_NO_START: assert property (any_flt && start_cmd |=> !running)
    else $error("start taken in fault");
  AST_START: assert property (start_cmd && !stop_cmd && safety_input_a && safety_input_b
    && !running && !any_flt |=> running) else $error("start refused");
  AST_LATCH: assert property (any_flt && !(safety_input_a && safety_input_b && fault_reset)
    |=> any_flt && !running) else $error("fault not held");
  AST_CODE_CUT: assert property ($rose(safe_torque_cutoff) |-> ##2 fault_code == 8'h28)
    else $error("cutoff code wrong");
  AST_CODE_DUAL: assert property ($rose(dual_channel_exception) |-> ##2 fault_code == 8'h2b)
    else $error("dual code wrong");
  AST_EXC_A: assert property (split_cnt_reg == EXC_LIM && !$past(safety_input_a)
    |-> (channel_a_exception || dual_channel_exception) && gate_drive_out == '0)
    else $error("a split not flagged");
  AST_EXC_B: assert property (split_cnt_reg == EXC_LIM && !$past(safety_input_b)
    |-> (channel_b_exception || dual_channel_exception) && gate_drive_out == '0)
    else $error("b split not flagged");
  cover property ($rose(safe_torque_cutoff));
  cover property ($rose(dual_channel_exception));
  cover property ($rose(channel_b_exception));
endmodule

bind torque_cutoff_monitor tcm_chk #(.TOL_CYC(TOL_CYC), .GATES(GATES), .IND_DLY(IND_DLY)) u_chk (
  .ref_clk, .rst_n, .clk_en, .safety_input_a, .safety_input_b, .start_cmd, .stop_cmd,
  .fault_reset, .gate_drive_in, .gate_drive_out, .running, .safe_torque_cutoff,
  .channel_a_exception, .channel_b_exception, .dual_channel_exception, .fault_code);

/* test/tcm_contacts.sv */
module tcm_contacts (
  input wire logic ref_clk, // system clock
  input wire logic [1:0] want, // wanted {a, b}, 1 = closed
  input wire logic [3:0] skew_b, // cycles contact b lags a
  output logic safety_input_a, // contact a
  output logic safety_input_b // contact b
);
  timeunit 1ns;
  timeprecision 1ps;
  // start closed so nothing unknown reaches the judge
  logic [15:0] b_hist_reg = 16'hffff;
  logic a_reg = 1'b1;
  always @(posedge ref_clk) begin
    a_reg <= want[1];
    b_hist_reg <= {b_hist_reg[14:0], want[0]};
  end
  assign safety_input_a = a_reg;
  assign safety_input_b = b_hist_reg[skew_b];
endmodule

/* test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TOL = 8;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic start_cmd = 1'b0;
  logic stop_cmd = 1'b0;
  logic fault_reset = 1'b0;
  logic [5:0] gate_drive_in = 6'h00;
  logic [5:0] gate_drive_out;
  logic running, safe_torque_cutoff, channel_a_exception;
  logic channel_b_exception, dual_channel_exception;
  logic [7:0] fault_code;
  logic [1:0] want = 2'h3;
  logic [3:0] skew_b = 4'h0;
  logic safety_input_a, safety_input_b;
  int n_errors = 0;
  int checks_done = 0;
  logic [5:0] q[$];

  tcm_contacts u_tcm_contacts (.ref_clk, .want, .skew_b, .safety_input_a, .safety_input_b);
  torque_cutoff_monitor #(.TOL_CYC(TOL)) u_torque_cutoff_monitor (.ref_clk, .rst_n, .clk_en,
    .safety_input_a, .safety_input_b, .start_cmd, .stop_cmd, .fault_reset, .gate_drive_in,
    .gate_drive_out, .running, .safe_torque_cutoff, .channel_a_exception,
    .channel_b_exception, .dual_channel_exception, .fault_code);

  initial forever #5 ref_clk = ~ref_clk;

  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_code(logic [7:0] exp, output int n);
    n = 0;
    while (fault_code !== exp && n < 60) begin
      tick();
      n++;
    end
    if (n == 60) begin
      chk("fault_code", exp, fault_code);
      end_sim();
    end
  endtask
  // expected code: a first split names its channel, a second split makes it dual
  function automatic logic [7:0] model_code(logic [1:0] w1, logic [1:0] w2);
    if (w2 != 2'h3) return 8'h2b;
    return (w1 == 2'h0) ? 8'h28 : (w1 == 2'h1) ? 8'h29 : 8'h2a;
  endfunction
  task automatic run_check();
    start_cmd = 1'b1;
    tick();
    start_cmd = 1'b0;
    chk("running", 8'h01, running);
    repeat (6) begin
      gate_drive_in = 6'($urandom);
      q.push_back(gate_drive_in);
      tick();
      chk("gate_drive_out", q.pop_front(), gate_drive_out);
    end
  endtask
  task automatic fault_case(logic [1:0] w1, logic [3:0] sk, logic [1:0] w2);
    logic [7:0] exp;
    int n;
    exp = model_code(w1, w2);
    skew_b = sk;
    run_check();
    want = w1;
    wait_code(model_code(w1, 2'h3), n);
    chk("indication delay", 8'h01, n <= TOL + 8);
    if (w2 != 2'h3) begin
      want = 2'h3;
      tick(2);
      want = w2;
      wait_code(exp, n);
    end
    chk("fault_code", exp, fault_code);
    chk("flags", {exp == 8'h28, w1 == 2'h1 && exp != 8'h28, w1 == 2'h2, exp == 8'h2b},
      {safe_torque_cutoff, channel_a_exception, channel_b_exception, dual_channel_exception});
    chk("gate_drive_out", 8'h00, gate_drive_out);
    start_cmd = 1'b1;
    tick();
    start_cmd = 1'b0;
    chk("running", 8'h00, running);
    want = 2'h3;
    // contact b closes sk cycles late; the reset must meet both closed
    tick(sk + 4);
    chk("latched code", exp, fault_code);
    chk("running", 8'h00, running);
    fault_reset = 1'b1;
    tick();
    fault_reset = 1'b0;
    wait_code(8'h00, n);
    chk("flags", 8'h00, {safe_torque_cutoff, channel_a_exception, channel_b_exception,
      dual_channel_exception});
    $display("case %h done", exp);
  endtask

  initial begin
    void'($urandom(32'ha0dbda69));
    tick(5);
    rst_n = 1'b1;
    chk("fault_code", 8'h00, fault_code);
    fault_case(2'h0, 4'h0, 2'h3);
    fault_case(2'h0, 4'h4, 2'h3);
    fault_case(2'h1, 4'h0, 2'h3);
    fault_case(2'h2, 4'h0, 2'h3);
    fault_case(2'h1, 4'h0, 2'h2);
    fault_case(2'h2, 4'h0, 2'h1);
    run_check();
    clk_en = 1'b0;
    stop_cmd = 1'b1;
    tick(2);
    chk("frozen running", 8'h01, running);
    clk_en = 1'b1;
    tick();
    stop_cmd = 1'b0;
    tick(3);
    chk("running", 8'h00, running);
    $display("stop case done");
    run_check();
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    chk("reset running", 8'h00, running);
    chk("reset fault_code", 8'h00, fault_code);
    $display("reset case done");
    end_sim();
  end
endmodule
